// ---- core/scs_config_clock_unit.sv ----
/*
  Configuration clock unit: generates the clock in master mode, finds its edges in slave mode,
  and delivers the serial data bit with a one-cycle strobe per rising edge.
  Assumes i_cfg_clk and i_din come from outside the system clock domain.
*/
`timescale 1ns/100ps
module scs_config_clock_unit
  import scs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cfg_clk,
  input wire logic i_din,
  input wire logic i_master,
  input wire logic i_run,
  input wire logic [1:0] i_rate,
  output logic o_config_clock,
  scs_ser_if.clk_mp sif
);
  logic [2:0] ck_q, ck_d;
  logic [2:0] dn_q, dn_d;
  logic [7:0] cnt_q, cnt_d;
  logic config_clock_q, config_clock_d;
  logic rise_q, rise_d;
  logic [7:0] half;

  always_comb begin
    case (i_rate)
      2'h1: half = half_cnt(RATE1_KHZ);
      2'h2: half = half_cnt(RATE2_KHZ);
      2'h3: half = half_cnt(RATE3_KHZ);
      default: half = HALF_BOOT;
    endcase
    ck_d = {ck_q[1:0], i_cfg_clk};
    // Third data stage lines the bit up with the delayed slave edge
    dn_d = {dn_q[1:0], i_din};
    cnt_d = cnt_q;
    config_clock_d = config_clock_q;
    rise_d = 1'b0;
    if (i_master) begin
      if (!i_run) begin
        cnt_d = 8'h00;
        config_clock_d = 1'b0;
      end else if (cnt_q >= half - 8'h01) begin
        cnt_d = 8'h00;
        config_clock_d = !config_clock_q;
        rise_d = !config_clock_q;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end else begin
      config_clock_d = 1'b0;
      rise_d = ck_q[1] && !ck_q[2];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ck_q <= 3'h0;
      dn_q <= 3'h0;
      cnt_q <= 8'h00;
      config_clock_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (i_ce) begin
      ck_q <= ck_d;
      dn_q <= dn_d;
      cnt_q <= cnt_d;
      config_clock_q <= config_clock_d;
      rise_q <= rise_d;
    end
  end

  assign o_config_clock = config_clock_q;
  assign sif.rise = rise_q && i_ce;
  assign sif.bit_v = dn_q[2];
endmodule : scs_config_clock_unit

// ---- core/scs_crc_unit.sv ----
/*
  Serial CRC over the payload bits, one bit per strobe, first bit first.
  Assumes the sequencer clears it before a load and enables it only for payload bits.
*/
`timescale 1ns/100ps
module scs_crc_unit
  import scs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  scs_ser_if.crc_mp sif
);
  logic [15:0] crc_q, crc_d;

  always_comb begin
    crc_d = crc_q;
    if (sif.crc_clr) begin
      crc_d = CRC_INIT;
    end else if (sif.crc_en && sif.rise) begin
      crc_d = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ sif.bit_v) ? CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      crc_q <= CRC_INIT;
    end else if (i_ce) begin
      crc_q <= crc_d;
    end
  end

  assign sif.crc = crc_q;
endmodule : scs_crc_unit

// ---- core/scs_pkg.sv ----
/*
  Shared constants, state type and helper functions of the serial configuration sequencer.
  Assumes a 100 MHz system clock; all cycle counts below derive from that rate.
*/
package scs_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int BOOT_KHZ = 2500;
  localparam int RATE1_KHZ = 4000;
  localparam int RATE2_KHZ = 10000;
  localparam int RATE3_KHZ = 25000;
  localparam int CLEAR_NS = 2000;
  localparam logic [15:0] CLEAR_CYC = 16'((CLEAR_NS * CLK_KHZ + 999999) / 1000000);

  // Half period of the generated clock in system cycles, never below one
  function automatic logic [7:0] half_cnt(input int khz);
    int h;
    h = CLK_KHZ / (2 * khz);
    half_cnt = (h < 1) ? 8'h01 : 8'(h);
  endfunction : half_cnt

  localparam logic [7:0] HALF_BOOT = half_cnt(BOOT_KHZ);

  // ---------------------------------------------------------------
  // Bitstream layout
  // ---------------------------------------------------------------
  localparam logic [15:0] LOAD_BITS = 16'h0400;
  localparam logic [15:0] RATE_POS = 16'h01DE;
  localparam logic [15:0] CRC_W = 16'h0010;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_3321;
  localparam int F_DONE = 0;
  localparam int F_GTS = 4;
  localparam int F_GSR = 8;
  localparam int F_GWE = 12;
  localparam int F_SYNC = 16;
  localparam int F_DRIVE = 17;
  localparam int F_LOCK_EN = 18;
  localparam int F_LOCK_PH = 20;
  localparam int F_LOCK_MASK = 24;

  // ---------------------------------------------------------------
  // Start-up phases and states
  // ---------------------------------------------------------------
  localparam logic [2:0] PH_MIN = 3'h1;
  localparam logic [2:0] PH_MAX = 3'h6;
  localparam logic [2:0] PH_LAST = 3'h7;

  typedef enum logic [2:0] {
    ST_CLEAR, ST_WAIT_INIT, ST_LOAD, ST_CHECK, ST_ABORT, ST_LOCKED, ST_STARTUP, ST_USER
  } scs_state_t;

  // Keeps a programmed event phase inside C1..C6
  function automatic logic [2:0] clamp_ph(input logic [2:0] p);
    clamp_ph = (p < PH_MIN) ? PH_MIN : ((p > PH_MAX) ? PH_MAX : p);
  endfunction : clamp_ph
endpackage : scs_pkg

// ---- core/scs_ser_if.sv ----
/*
  Serial bit path between the clock unit, the CRC unit and the sequencer.
  Assumes all three parties run on the system clock.
*/
`timescale 1ns/100ps
interface scs_ser_if;
  logic rise;
  logic bit_v;
  logic crc_clr;
  logic crc_en;
  logic [15:0] crc;
  modport clk_mp (output rise, output bit_v);
  modport crc_mp (input rise, input bit_v, input crc_clr, input crc_en, output crc);
  modport ctl_mp (input rise, input bit_v, input crc, output crc_clr, output crc_en);
endinterface : scs_ser_if

// ---- core/scs_top.sv ----
/*
  Serial configuration sequencer: clear phase, mode sampling, serial load with CRC check,
  eight-phase start-up and daisy-chain pass-through, with an APB register slave.
  Assumes pins are asynchronous to i_clk_sys and open-drain wires are resolved outside.
*/
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
module scs_top
  import scs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_prog_n,
  input wire logic i_init_n,
  output logic o_init_n,
  output logic o_init_n_oe,
  input wire logic [2:0] i_mode_select,
  input wire logic i_cfg_clk,
  output logic o_cfg_clk,
  output logic o_cfg_clk_oe,
  input wire logic i_din,
  output logic o_dout,
  input wire logic i_done,
  output logic o_done,
  output logic o_done_oe,
  input wire logic [1:0] i_dll_lock,
  output logic o_global_output_tristate,
  output logic o_global_flop_reset,
  output logic o_global_store_enable,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] sy1_q, sy2_q;
  logic prog_s, init_s, done_s;
  logic [2:0] mode_s;
  logic [1:0] lock_s;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sy1_q <= 8'h00;
      sy2_q <= 8'h00;
    end else if (i_ce) begin
      sy1_q <= {i_prog_n, i_init_n, i_done, i_mode_select, i_dll_lock};
      sy2_q <= sy1_q;
    end
  end
  assign {prog_s, init_s, done_s, mode_s, lock_s} = sy2_q;

  // ---------------------------------------------------------------
  // Serial path
  // ---------------------------------------------------------------
  scs_ser_if sif ();
  logic master_q, master_d;
  logic [1:0] rate_q, rate_d;
  scs_state_t state_q, state_d;

  scs_config_clock_unit u_config_clock (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_cfg_clk(i_cfg_clk),
    .i_din(i_din),
    .i_master(master_q),
    .i_run(state_q inside {ST_LOAD, ST_CHECK, ST_STARTUP}),
    .i_rate(rate_q),
    .o_config_clock(o_cfg_clk),
    .sif(sif.clk_mp)
  );

  scs_crc_unit u_crc (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .sif(sif.crc_mp)
  );

  // ---------------------------------------------------------------
  // Register settings
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [2:0] done_ph, gts_ph, gsr_ph, gwe_ph, lock_ph;
  logic sync_opt, drive_opt, lock_en;
  logic [1:0] lock_mask;

  assign done_ph = clamp_ph(ctrl_q[F_DONE +: 3]);
  assign gts_ph = clamp_ph(ctrl_q[F_GTS +: 3]);
  assign gsr_ph = clamp_ph(ctrl_q[F_GSR +: 3]);
  assign gwe_ph = clamp_ph(ctrl_q[F_GWE +: 3]);
  assign sync_opt = ctrl_q[F_SYNC];
  assign drive_opt = ctrl_q[F_DRIVE];
  assign lock_en = ctrl_q[F_LOCK_EN];
  assign lock_ph = ctrl_q[F_LOCK_PH +: 3];
  assign lock_mask = ctrl_q[F_LOCK_MASK +: 2];

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic [15:0] clr_cnt_q, clr_cnt_d, bit_cnt_q, bit_cnt_d, shift_q, shift_d;
  logic [2:0] mode_q, mode_d, phase_q, phase_d;
  logic crc_err_q, crc_err_d, done_q, done_d, gts_q, gts_d, gsr_q, gsr_d, gwe_q, gwe_d;
  logic seen_q, seen_d, dout_q, dout_d, init_oe_q, init_oe_d, init_out_q;
  logic done_oe_q, done_oe_d, config_clock_oe_q;
  logic lock_pause, wait_ext, hold;

  assign lock_pause = lock_en && (phase_q == lock_ph) && ((lock_s & lock_mask) != lock_mask);
  assign wait_ext = sync_opt && done_q && !seen_q;
  assign hold = lock_pause || wait_ext;

  always_comb begin
    state_d = state_q;
    clr_cnt_d = clr_cnt_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    mode_d = mode_q;
    master_d = master_q;
    rate_d = rate_q;
    phase_d = phase_q;
    crc_err_d = crc_err_q;
    done_d = done_q;
    gts_d = gts_q;
    gsr_d = gsr_q;
    gwe_d = gwe_q;
    seen_d = seen_q;
    dout_d = dout_q;
    sif.crc_clr = 1'b0;
    sif.crc_en = 1'b0;
    if (!prog_s) begin
      state_d = ST_CLEAR;
      clr_cnt_d = 16'h0000;
      done_d = 1'b0;
      gts_d = 1'b1;
      gsr_d = 1'b1;
      gwe_d = 1'b0;
      crc_err_d = 1'b0;
      master_d = 1'b0;
    end else begin
      case (state_q)
        ST_CLEAR: begin
          if (clr_cnt_q >= CLEAR_CYC - 16'h0001) begin
            state_d = ST_WAIT_INIT;
          end else begin
            clr_cnt_d = clr_cnt_q + 16'h0001;
          end
        end
        ST_WAIT_INIT: begin
          sif.crc_clr = 1'b1;
          bit_cnt_d = 16'h0000;
          rate_d = 2'h0;
          if (init_s) begin
            mode_d = mode_s;
            if (mode_s[1:0] == 2'b11) begin
              state_d = ST_LOAD;
            end else if (mode_s[1:0] == 2'b00) begin
              master_d = 1'b1;
              state_d = ST_LOAD;
            end else begin
              state_d = ST_LOCKED;
            end
          end
        end
        ST_LOAD: begin
          if (sif.rise) begin
            sif.crc_en = bit_cnt_q < LOAD_BITS;
            shift_d = {shift_q[14:0], sif.bit_v};
            bit_cnt_d = bit_cnt_q + 16'h0001;
            if (bit_cnt_q == RATE_POS + 16'h0001) begin
              rate_d = {shift_q[0], sif.bit_v};
            end
            if (bit_cnt_q == LOAD_BITS + CRC_W - 16'h0001) begin
              state_d = ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (shift_q == sif.crc) begin
            state_d = ST_STARTUP;
            phase_d = 3'h0;
            seen_d = 1'b0;
          end else begin
            crc_err_d = 1'b1;
            state_d = ST_ABORT;
          end
        end
        ST_STARTUP: begin
          if (sif.rise) begin
            dout_d = sif.bit_v;
            if (sync_opt && done_q && done_s) begin
              seen_d = 1'b1;
            end
            if (sync_opt && seen_q) begin
              gts_d = 1'b0;
              gsr_d = 1'b0;
              gwe_d = 1'b1;
            end
            if (!hold) begin
              phase_d = phase_q + 3'h1;
              if (phase_d == done_ph) begin
                done_d = 1'b1;
              end
              if (!sync_opt && phase_d == gts_ph) begin
                gts_d = 1'b0;
              end
              if (!sync_opt && phase_d == gsr_ph) begin
                gsr_d = 1'b0;
              end
              if (!sync_opt && phase_d == gwe_ph) begin
                gwe_d = 1'b1;
              end
              if (phase_q == PH_LAST) begin
                state_d = ST_USER;
              end
            end
          end
        end
        ST_USER: begin
          if (sif.rise) begin
            dout_d = sif.bit_v;
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
    init_oe_d = (state_d == ST_CLEAR) || (state_d == ST_ABORT);
    done_oe_d = !done_d || drive_opt;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_CLEAR;
      clr_cnt_q <= 16'h0000;
      bit_cnt_q <= 16'h0000;
      shift_q <= 16'h0000;
      mode_q <= 3'h7;
      master_q <= 1'b0;
      rate_q <= 2'h0;
      phase_q <= 3'h0;
      crc_err_q <= 1'b0;
      done_q <= 1'b0;
      gts_q <= 1'b1;
      gsr_q <= 1'b1;
      gwe_q <= 1'b0;
      seen_q <= 1'b0;
      dout_q <= 1'b0;
      init_oe_q <= 1'b1;
      init_out_q <= 1'b0;
      done_oe_q <= 1'b1;
      config_clock_oe_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      clr_cnt_q <= clr_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      mode_q <= mode_d;
      master_q <= master_d;
      rate_q <= rate_d;
      phase_q <= phase_d;
      crc_err_q <= crc_err_d;
      done_q <= done_d;
      gts_q <= gts_d;
      gsr_q <= gsr_d;
      gwe_q <= gwe_d;
      seen_q <= seen_d;
      dout_q <= dout_d;
      init_oe_q <= init_oe_d;
      init_out_q <= !init_oe_d;
      done_oe_q <= done_oe_d;
      config_clock_oe_q <= master_d;
    end
  end

  assign o_init_n = init_out_q;
  assign o_init_n_oe = init_oe_q;
  assign o_cfg_clk_oe = config_clock_oe_q;
  assign o_dout = dout_q;
  assign o_done = done_q;
  assign o_done_oe = done_oe_q;
  assign o_global_output_tristate = gts_q;
  assign o_global_flop_reset = gsr_q;
  assign o_global_store_enable = gwe_q;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero-wait slave: pready rises in the first access cycle
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, hit;

  always_comb begin
    ctrl_d = ctrl_q;
    prdata_d = prdata_q;
    pready_d = psel && !penable;
    pslverr_d = 1'b0;
    hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT);
    if (psel && !penable) begin
      pslverr_d = !hit;
      prdata_d = 32'h0000_0000;
      if (!pwrite && paddr == ADDR_CTRL) begin
        prdata_d = ctrl_q;
      end else if (!pwrite && paddr == ADDR_STAT) begin
        prdata_d = {14'h0000, rate_q, 1'b0, phase_q, 3'h0, crc_err_q, 1'b0, mode_q, 1'b0, 3'(state_q)};
      end
    end
    if (psel && penable && pready_q && pwrite && paddr == ADDR_CTRL) begin
      ctrl_d = pwdata;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (i_ce) begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_restart;
    i_ce && !prog_s;
  endsequence
  sequence s_check_bad;
    i_ce && prog_s && state_q == ST_CHECK && shift_q != sif.crc;
  endsequence

  a_clear_drive: assert property (state_q == ST_CLEAR |-> o_init_n_oe && !o_init_n)
    else $error("clear-status not driven low while clearing");
  a_prog_restart: assert property (s_restart |=> state_q == ST_CLEAR && !o_done)
    else $error("request did not restart clearing");
  a_user_ack: assert property (state_q == ST_USER ##0 s_restart |=> !o_done ##1 o_init_n_oe)
    else $error("request in user mode not acknowledged");
  a_crc_abort: assert property (s_check_bad |=> state_q == ST_ABORT && o_init_n_oe && crc_err_q)
    else $error("CRC mismatch did not abort");
  a_crc_start: assert property (i_ce && prog_s && state_q == ST_CHECK && shift_q == sif.crc
    |=> state_q == ST_STARTUP && phase_q == 3'h0)
    else $error("CRC match did not start up");
  a_mode_sample: assert property (i_ce && prog_s && state_q == ST_WAIT_INIT && init_s
    |=> mode_q == $past(mode_s) && !o_init_n_oe)
    else $error("mode not sampled on release");
  a_phase_hold: assert property (i_ce && state_q == ST_STARTUP && prog_s && (hold || !sif.rise)
    |=> $stable(phase_q))
    else $error("phase moved while held");
  a_gts_phase: assert property (i_ce && prog_s && state_q == ST_STARTUP && sif.rise && !hold && !sync_opt
    && phase_q + 3'h1 == gts_ph |=> !o_global_output_tristate)
    else $error("tristate not released at its phase");
  a_master_clk: assert property (i_ce && prog_s && state_q == ST_LOAD && master_q |=> o_cfg_clk_oe)
    else $error("master clock not driven");
  a_dout_pass: assert property (i_ce && prog_s && state_q == ST_USER && sif.rise |=> o_dout == $past(sif.bit_v))
    else $error("chain output not updated");
endmodule : scs_top

// ---- test/scs_src_model.sv ----
/*
  Slave serial source: supplies the configuration clock, serial data and an open-drain hold on clear-status.
  Assumes the bench resolves the clear-status wire from all pull-down enables.
*/
`timescale 1ns/100ps
module scs_src_model (
  output logic o_config_clock,
  output logic o_din,
  output logic o_init_hold
);
  initial begin
    o_config_clock = 1'b0;
    o_din = 1'b0;
    o_init_hold = 1'b0;
  end
  // Open-drain pull-down only, never drives high
  task automatic hold_init(input logic h);
    o_init_hold <= h;
  endtask : hold_init
  // Clock stands low between bits; old data is not held past the fall
  // One bit per 80 ns, data set up 30 ns ahead of the rising edge
  task automatic send(input logic b);
    o_din <= b;
    #30 o_config_clock <= 1'b1;
    #40 o_config_clock <= 1'b0;
    o_din <= ~b;
    #10;
  endtask : send
endmodule : scs_src_model

// ---- test/testbench.sv ----
/*
  Self-checking bench: slave serial loads with good and bad CRC, start-up, chain, APB reads.
  Assumes the package constants and the APB map of the sequencer.
*/
`timescale 1ns/100ps
module testbench
  import scs_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_prog_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, seed = 32'hC6F0;
  logic pready, pslverr, er, init_n, init_oe, dout, done, done_oe, global_output_tristate, global_flop_reset, global_store_enable, config_clock, din, hold, ccoe;
  logic cfgclk;
  logic ce = 1'b1;
  logic [2:0] mode_pins = 3'b111;
  logic [1:0] dll_lock = 2'b11;
  logic bits[$];
  int err_total = 0;
  int cmp_count = 0;
  realtime t_done, t_gts, t_gsr;
  wire init_w = ~(init_oe | hold);
  wire done_w = done_oe ? done : 1'b1;
  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge done) t_done = $realtime;
  always @(negedge global_output_tristate) t_gts = $realtime;
  always @(negedge global_flop_reset) t_gsr = $realtime;
  scs_src_model src_u (.o_config_clock(config_clock), .o_din(din), .o_init_hold(hold));
  scs_top dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce), .i_prog_n(i_prog_n),
    .i_init_n(init_w), .o_init_n(init_n), .o_init_n_oe(init_oe), .i_mode_select(mode_pins),
    .i_cfg_clk(config_clock), .o_cfg_clk(cfgclk), .o_cfg_clk_oe(ccoe), .i_din(din), .o_dout(dout),
    .i_done(done_w), .o_done(done), .o_done_oe(done_oe), .i_dll_lock(dll_lock),
    .o_global_output_tristate(global_output_tristate), .o_global_flop_reset(global_flop_reset), .o_global_store_enable(global_store_enable),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // --------
  // Tasks
  // --------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Counts the clear phase; the source waits for the line to go high
  task automatic wait_init(input int lo, input int hi);
    int n;
    n = 0;
    while (init_w !== 1'b1 && n < 2000) begin
      @(posedge i_clk_sys);
      n++;
    end
    chk("clear_len", 1, n >= lo && n <= hi);
    // Mode is latched only after the released line passes the synchroniser
    repeat (4) @(posedge i_clk_sys);
  endtask : wait_init
  // Model CRC: shift left, feedback is top bit xor data
  task automatic load(input logic bad);
    logic [15:0] c;
    logic [31:0] r;
    bits.delete();
    c = 16'h0000;
    for (int i = 0; i < LOAD_BITS; i++) begin
      r = rnd();
      bits.push_back(r[0]);
      c = {c[14:0], 1'b0} ^ ((c[15] ^ r[0]) ? CRC_POLY : 16'h0000);
    end
    c[0] = c[0] ^ bad;
    foreach (bits[i]) src_u.send(bits[i]);
    for (int i = 15; i >= 0; i--) src_u.send(c[i]);
  endtask : load
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // --------
  // Sequence
  // --------
  initial begin
    #600000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] r;
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    wait_init(200, 215);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("stat_mode", 32'h72, rd & 32'h77);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_rst", CTRL_RESET, rd);
    apb(1'b1, 12'h008, rnd());
    chk("unmapped", 1, er);
    load(1'b0);
    repeat (9) src_u.send(1'b1);
    chk("done", 1, done);
    chk("gts", 0, global_output_tristate);
    chk("gsr", 0, global_flop_reset);
    chk("gwe", 1, global_store_enable);
    chk("gts_lag", 80, int'(t_gts - t_done));
    chk("gsr_lag", 80, int'(t_gsr - t_gts));
    chk("config_clock_oe", 0, ccoe);
    chk("cfg_clk", 0, cfgclk);
    chk("done_oe", 0, done_oe);
    repeat (8) begin
      r = rnd();
      src_u.send(r[0]);
      chk("dout", r[0], dout);
    end
    $display("test good load ended");
    i_prog_n <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    chk("done_ack", 0, done);
    chk("clear_drv", 1, init_oe);
    src_u.hold_init(1'b1);
    i_prog_n <= 1'b1;
    repeat (400) @(posedge i_clk_sys);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("held", 1, rd[2:0] < 3'h2);
    src_u.hold_init(1'b0);
    wait_init(0, 1);
    load(1'b1);
    repeat (10) @(posedge i_clk_sys);
    chk("crc_abort", 1, init_oe);
    chk("init_low", 0, init_n);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("crc_stat", 32'h104, rd & 32'h107);
    repeat (9) src_u.send(1'b1);
    chk("stay_abort", 0, done);
    $display("test bad crc ended");
    i_prog_n <= 1'b0;
    mode_pins <= 3'b101;
    repeat (10) @(posedge i_clk_sys);
    i_prog_n <= 1'b1;
    wait_init(200, 215);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("stat_scan", 32'h55, rd & 32'h77);
    $display("test restart ended");
    tally_and_finish();
  end
endmodule : testbench
